/* rtl/pin_sync.sv */
// Two-stage synchroniser for the link pins
`timescale 1ns/100ps
module pin_sync (
	input  wire logic          clock,
	input  wire logic          rst,
	input  wire logic          ce,
	input  wire tdm_pkg::pins_t raw_pins,
	output tdm_pkg::pins_t     sync_pins
);
	tdm_pkg::sync_state_t s_reg;
	tdm_pkg::sync_state_t s_next;

	always_comb begin
		s_next = s_reg;
		if (ce) begin
			s_next.meta   = raw_pins;
			s_next.stable = s_reg.meta;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign sync_pins = s_reg.stable;
endmodule

/* rtl/tdm_command_audio_port.sv */
// Multiplexed command/audio link receiver with APB register slave
//
// What this block does
// - Multiplexed mode is recognised from a frame strobe two bit clocks long.
// - Mode is entered only after two consecutive qualifying frames.
// - Commands are accepted from the frame after mode entry.
// - Read-data output is tri-statable for a shared return line.
// - Up to 30 device ids on one chain.
// - A device with chain input tied high becomes id 1.
// - Other devices count bit clocks while watching chain input for their id.
// - Fields are 32 bits, MSB first; the lowest byte is ignored.
// - Extended flag adds command packets; such frames carry no audio.
// - Device decodes both command and extended command fields.
// - Two own audio channels are taken only while output-enable bit is low.
// - Id-enable set makes the frame an id frame; other bits ignored.
// - Command layout: id-en, ext, chain-sel, id, r/w, reg, data, unused.
// - Write to id all ones is broadcast; id zero selects nobody.
// - Input sampled on bit-clock rise, read output changes on fall.
// - Read output enabled one bit clock before the read data.
// - Chain output high during the last own audio channel while output-enable bit is low; passes chain input through while it is set.
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/100ps
module tdm_command_audio_port (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        frame_strobe_pin,
	input  wire logic        bit_clock_pin,
	input  wire logic        serial_in_pin,
	input  wire logic        chain_in_pin,
	output logic             chain_out_pin,
	output logic             read_out_pin_o,
	output logic             read_out_pin_oe,
	output logic      [23:0] audio_left,
	output logic      [23:0] audio_right,
	output logic             sample_valid
);
	tdm_pkg::pins_t      raw;
	tdm_pkg::pins_t      syn;
	tdm_pkg::port_state_t s_reg;
	tdm_pkg::port_state_t s_next;
	logic                bck_rise;
	logic                bck_fall;

	assign raw.lrck  = frame_strobe_pin;
	assign raw.bck   = bit_clock_pin;
	assign raw.data  = serial_in_pin;
	assign raw.chain = chain_in_pin;

	pin_sync u_sync (
		.clock     (clock),
		.rst       (rst),
		.ce        (ce),
		.raw_pins  (raw),
		.sync_pins (syn)
	);

	assign bck_rise = ce & syn.bck & ~s_reg.bck_prev;
	assign bck_fall = ce & ~syn.bck & s_reg.bck_prev;

	function automatic logic [5:0] right_slot(input logic [4:0] id);
		return {id, 1'b0};
	endfunction

	function automatic logic [5:0] next_field(input logic [4:0] b, input logic [5:0] f);
		if (b == tdm_pkg::LAST_BIT && f != tdm_pkg::FIELD_SAT) begin
			return f + 6'h01;
		end
		return f;
	endfunction

	// field decode; broadcast only for writes, zero matches nobody
	function automatic logic addressed(input logic [31:0] w, input logic [4:0] id,
			input logic idv);
		logic [4:0] d;
		d = w[tdm_pkg::F_DEV_MSB:tdm_pkg::F_DEV_LSB];
		if (w[tdm_pkg::F_CHAIN] || d == tdm_pkg::ID_NONE) begin
			return 1'b0;
		end
		return (idv && d == id) || (!w[tdm_pkg::F_RW] && d == tdm_pkg::ID_BROADCAST);
	endfunction

	// same decode for command and extended fields
	function automatic tdm_pkg::port_state_t apply_cmd(input tdm_pkg::port_state_t s,
			input logic [31:0] w);
		tdm_pkg::port_state_t r;
		logic [6:0]           rid;
		r   = s;
		rid = w[tdm_pkg::F_REG_MSB:tdm_pkg::F_REG_LSB];
		if (addressed(w, s.dev_id, s.id_valid)) begin
			if (w[tdm_pkg::F_RW]) begin
				r.rd_active = 1'b1;
				if (rid == tdm_pkg::OEB_REG_ID) begin
					r.rd_data = 8'h00;
					r.rd_data[tdm_pkg::OEB_DATA_BIT] = s.output_enable_bit;
				end else if (rid == tdm_pkg::DEVID_REG_ID) begin
					r.rd_data = {3'h0, s.dev_id};
				end else begin
					r.rd_data = s.reply;
				end
			end else begin
				r.cmd_log = {rid, w[tdm_pkg::F_DAT_MSB:tdm_pkg::F_DAT_LSB]};
				r.cmd_new = 1'b1;
				if (rid == tdm_pkg::OEB_REG_ID) begin
					r.output_enable_bit = w[tdm_pkg::F_DAT_LSB + tdm_pkg::OEB_DATA_BIT];
				end
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] read_word(input tdm_pkg::port_state_t s,
			input logic [7:0] a, output logic bad);
		logic [31:0] r;
		r   = 32'h0000_0000;
		bad = 1'b0;
		case (a)
			tdm_pkg::CTRL_OFF: begin
				r[tdm_pkg::CTRL_OEB_BIT] = s.output_enable_bit;
			end
			tdm_pkg::STATUS_OFF: begin
				r[tdm_pkg::ST_MODE_BIT] = s.mode;
				r[tdm_pkg::ST_IDV_BIT] = s.id_valid;
				r[tdm_pkg::ST_ID_LSB +: 5] = s.dev_id;
			end
			tdm_pkg::CMD_OFF: begin
				r[tdm_pkg::CMD_LOG_LSB +: 15] = s.cmd_log;
				r[tdm_pkg::CMD_NEW_BIT] = s.cmd_new;
			end
			tdm_pkg::REPLY_OFF: r[tdm_pkg::REPLY_LSB +: 8] = s.reply;
			tdm_pkg::AUDL_OFF:  r[tdm_pkg::AUD_LSB +: 24] = s.audio_l;
			tdm_pkg::AUDR_OFF:  r[tdm_pkg::AUD_LSB +: 24] = s.audio_r;
			default:            bad = 1'b1;
		endcase
		return r;
	endfunction

	assign pready = ce & psel & penable & s_reg.apb_ph;

	always_comb begin
		logic [31:0] word;
		logic [4:0]  cur;
		logic [5:0]  cur_field;
		logic [4:0]  nb;
		logic [5:0]  nf;
		logic        start;
		logic        bad;
		word      = {s_reg.shift, syn.data};
		start     = syn.lrck & ~s_reg.lrck_prev;
		cur       = start ? 5'h00 : s_reg.bit_idx + 5'h01;
		cur_field = start ? 6'h00 : next_field(s_reg.bit_idx, s_reg.field);
		nb        = s_reg.bit_idx + 5'h01;
		nf        = next_field(s_reg.bit_idx, s_reg.field);
		bad       = 1'b0;
		s_next    = s_reg;
		if (ce) begin
			s_next.bck_prev     = syn.bck;
			s_next.sample_pulse = 1'b0;
			// Read data captured in setup so it stands registered in access
			if (psel && !penable) begin
				s_next.rdata  = read_word(s_reg, paddr, bad);
				s_next.err    = bad;
				s_next.apb_ph = 1'b1;
			end
			// Bus writes first so a link event in the same cycle wins
			if (pready) begin
				s_next.apb_ph = 1'b0;
				if (pwrite && !s_reg.err) begin
					case (paddr)
						tdm_pkg::CTRL_OFF:  s_next.output_enable_bit = pwdata[tdm_pkg::CTRL_OEB_BIT];
						tdm_pkg::CMD_OFF: begin
							if (pwdata[tdm_pkg::CMD_NEW_BIT]) begin
								s_next.cmd_new = 1'b0;
							end
						end
						tdm_pkg::REPLY_OFF: s_next.reply = pwdata[tdm_pkg::REPLY_LSB +: 8];
						default:            s_next.err = s_reg.err;
					endcase
				end
			end
		end
		if (bck_rise) begin
			s_next.lrck_prev = syn.lrck;
			s_next.shift     = word[30:0];
			s_next.bit_idx   = cur;
			s_next.field     = cur_field;
			if (syn.lrck && s_reg.hi_cnt != 2'h3) begin
				s_next.hi_cnt = s_reg.hi_cnt + 2'h1;
			end
			if (start) begin
				s_next.hi_cnt      = 2'h1;
				// mode reached in an earlier frame enables commands here
				s_next.frame_mode  = s_reg.mode;
				s_next.in_frame    = 1'b1;
				s_next.ext_pending = 1'b0;
				s_next.audio_off   = 1'b0;
				s_next.id_frame    = 1'b0;
			end else if (!syn.lrck && s_reg.lrck_prev) begin
				s_next.hi_cnt = 2'h0;
				// strobe must have been high for exactly two bit clocks
				if (s_reg.hi_cnt == tdm_pkg::QUAL_PULSE_BCKS) begin
					// second consecutive qualifying frame enters the mode
					if (s_reg.qual_cnt != tdm_pkg::QUAL_FRAMES) begin
						s_next.qual_cnt = s_reg.qual_cnt + 2'h1;
					end
					s_next.mode = (s_reg.qual_cnt + 2'h1) >= tdm_pkg::QUAL_FRAMES;
				end else begin
					s_next.qual_cnt   = 2'h0;
					s_next.mode       = 1'b0;
					s_next.frame_mode = 1'b0;
				end
			end
			// tied-high chain input is seen at bit 0, giving id 1
			// ids up to 30, counted in bit clocks across the id field
			if (s_reg.id_frame && cur_field == 6'h01 && !s_reg.id_valid && syn.chain
					&& cur < tdm_pkg::ID_MAX) begin
				s_next.dev_id   = cur + 5'h01;
				s_next.id_valid = 1'b1;
			end
			if (cur == tdm_pkg::LAST_BIT && s_reg.in_frame && s_reg.frame_mode) begin
				s_next.rd_active = 1'b0;
				if (cur_field == 6'h00) begin
					// id frame ignores the rest of the command field
					if (word[tdm_pkg::F_ID_EN]) begin
						s_next.id_frame = 1'b1;
						s_next.id_valid = 1'b0;
						s_next.dev_id   = tdm_pkg::ID_NONE;
					end else begin
						s_next             = apply_cmd(s_next, word);
						s_next.ext_pending = word[tdm_pkg::F_EXT];
						// extended packets replace audio for this frame
						s_next.audio_off   = word[tdm_pkg::F_EXT];
					end
				end else if (s_reg.ext_pending) begin
					s_next             = apply_cmd(s_next, word);
					s_next.ext_pending = word[tdm_pkg::F_EXT];
				end else if (!s_reg.audio_off && !s_reg.id_frame && s_reg.id_valid
						&& !s_reg.output_enable_bit) begin
					// two channels taken while output-enable bit is low
					// low byte of the audio field discarded
					if (cur_field == right_slot(s_reg.dev_id) - 6'h01) begin
						s_next.audio_l = word[31:tdm_pkg::AUD_FLD_LSB];
					end else if (cur_field == right_slot(s_reg.dev_id)) begin
						s_next.audio_r      = word[31:tdm_pkg::AUD_FLD_LSB];
						s_next.sample_pulse = 1'b1;
					end
				end
			end
		end
		if (bck_fall) begin
			// output changes only on the bit-clock fall
			// enable rises one bit ahead of the data byte
			// driven only while answering an own read
			s_next.out_en = s_reg.rd_active && s_reg.bit_idx >= tdm_pkg::RD_OE_FIRST
				&& s_reg.bit_idx <= tdm_pkg::RD_OE_LAST;
			if (s_next.out_en && s_reg.bit_idx != tdm_pkg::RD_OE_FIRST) begin
				s_next.out_bit = s_reg.rd_data[3'(tdm_pkg::RD_OE_LAST - s_reg.bit_idx)];
			end else begin
				s_next.out_bit = 1'b0;
			end
			if (!s_reg.frame_mode) begin
				s_next.chain_out = 1'b0;
			end else if (s_reg.id_frame) begin
				// Passes the id token on from the bit after our own
				s_next.chain_out = s_reg.id_valid && nf == 6'h01 && nb >= s_reg.dev_id;
			end else if (s_reg.output_enable_bit) begin
				// Skipped device hands ownership straight through
				s_next.chain_out = syn.chain;
			end else begin
				// high during the last own channel
				s_next.chain_out = s_reg.id_valid && !s_reg.audio_off
					&& !s_reg.ext_pending && nf == right_slot(s_reg.dev_id);
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign prdata          = s_reg.rdata;
	assign pslverr         = pready & s_reg.err;
	assign chain_out_pin   = s_reg.chain_out;
	// separate enable lets the pad float the shared line
	assign read_out_pin_o  = s_reg.out_bit;
	assign read_out_pin_oe = s_reg.out_en;
	assign audio_left      = s_reg.audio_l;
	assign audio_right     = s_reg.audio_r;
	assign sample_valid    = s_reg.sample_pulse;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	property p_mode_pulse;
		$rose(s_reg.mode) |-> $past(s_reg.hi_cnt) == tdm_pkg::QUAL_PULSE_BCKS;
	endproperty
	a_mode_pulse: assert property (p_mode_pulse)
		else $error("mode entered without a two-bit-clock strobe");

	property p_mode_frames;
		$rose(s_reg.mode) |-> $past(s_reg.qual_cnt) == 2'h1;
	endproperty
	a_mode_frames: assert property (p_mode_frames)
		else $error("mode entered before two qualifying frames");

	property p_cmd_in_mode;
		$rose(s_reg.cmd_new) |-> s_reg.frame_mode;
	endproperty
	a_cmd_in_mode: assert property (p_cmd_in_mode)
		else $error("command taken outside a mode frame");

	property p_oe_own_read;
		s_reg.out_en |-> s_reg.rd_active;
	endproperty
	a_oe_own_read: assert property (p_oe_own_read)
		else $error("read output driven without an own read");

	property p_oe_early;
		$rose(s_reg.out_en) |-> s_reg.bit_idx == tdm_pkg::RD_OE_FIRST;
	endproperty
	a_oe_early: assert property (p_oe_early)
		else $error("read output enable not one bit early");

	property p_id_range;
		s_reg.id_valid |-> s_reg.dev_id >= tdm_pkg::ID_TOP && s_reg.dev_id <= tdm_pkg::ID_MAX;
	endproperty
	a_id_range: assert property (p_id_range)
		else $error("device id out of range");

	property p_id_count;
		$rose(s_reg.id_valid) |-> s_reg.dev_id == 5'(s_reg.bit_idx + 5'h01);
	endproperty
	a_id_count: assert property (p_id_count)
		else $error("device id does not match bit position");

	property p_no_audio_ext;
		s_reg.sample_pulse |-> !s_reg.audio_off && !s_reg.id_frame;
	endproperty
	a_no_audio_ext: assert property (p_no_audio_ext)
		else $error("audio taken from an extended or id frame");

	property p_skip_gate;
		s_reg.sample_pulse |-> !$past(s_reg.output_enable_bit);
	endproperty
	a_skip_gate: assert property (p_skip_gate)
		else $error("audio taken while output-enable bit set");

	property p_out_on_fall;
		$changed(s_reg.out_en) || $changed(s_reg.out_bit) |-> $past(bck_fall);
	endproperty
	a_out_on_fall: assert property (p_out_on_fall)
		else $error("read output changed away from a bit-clock fall");
endmodule

/* rtl/tdm_pkg.sv */
// Shared constants and carrier types for the multiplexed command/audio port
package tdm_pkg;

	// Register byte offsets
	localparam logic [7:0] CTRL_OFF   = 8'h00;
	localparam logic [7:0] STATUS_OFF = 8'h04;
	localparam logic [7:0] CMD_OFF    = 8'h08;
	localparam logic [7:0] REPLY_OFF  = 8'h0c;
	localparam logic [7:0] AUDL_OFF   = 8'h10;
	localparam logic [7:0] AUDR_OFF   = 8'h14;

	// Register field positions
	localparam int CTRL_OEB_BIT   = 0;
	localparam int ST_MODE_BIT    = 0;
	localparam int ST_IDV_BIT     = 1;
	localparam int ST_ID_LSB      = 8;
	localparam int CMD_NEW_BIT    = 16;
	localparam int CMD_LOG_LSB    = 0;
	localparam int REPLY_LSB      = 0;
	localparam int AUD_LSB        = 0;

	// Reset values
	localparam logic       OEB_RESET   = 1'h0;
	localparam logic [7:0] REPLY_RESET = 8'h00;

	// Command and audio field layout
	localparam int F_ID_EN   = 31;
	localparam int F_EXT     = 30;
	localparam int F_CHAIN   = 29;
	localparam int F_DEV_MSB = 28;
	localparam int F_DEV_LSB = 24;
	localparam int F_RW      = 23;
	localparam int F_REG_MSB = 22;
	localparam int F_REG_LSB = 16;
	localparam int F_DAT_MSB = 15;
	localparam int F_DAT_LSB = 8;
	localparam int AUD_FLD_LSB = 8;

	localparam logic [4:0] ID_BROADCAST = 5'h1f;
	localparam logic [4:0] ID_NONE      = 5'h00;
	localparam logic [4:0] ID_TOP       = 5'h01;
	localparam logic [4:0] ID_MAX       = 5'h1e;

	// Link register ids and bits
	localparam logic [6:0] OEB_REG_ID   = 7'h13;
	localparam logic [6:0] DEVID_REG_ID = 7'h17;
	localparam int         OEB_DATA_BIT = 4;

	// Link timing counts in bit-clock periods, bit positions, frames and fields
	localparam logic [1:0] QUAL_PULSE_BCKS = 2'h2;
	localparam logic [1:0] QUAL_FRAMES     = 2'h2;
	localparam logic [4:0] LAST_BIT        = 5'h1f;
	localparam logic [4:0] RD_OE_FIRST     = 5'h07;
	localparam logic [4:0] RD_OE_LAST      = 5'h0f;
	localparam logic [5:0] FIELD_SAT       = 6'h3f;

	typedef struct packed {
		logic lrck;
		logic bck;
		logic data;
		logic chain;
	} pins_t;

	typedef struct packed {
		pins_t meta;
		pins_t stable;
	} sync_state_t;

	typedef struct packed {
		logic        bck_prev;
		logic        lrck_prev;
		logic [1:0]  hi_cnt;
		logic [1:0]  qual_cnt;
		logic        mode;
		logic        frame_mode;
		logic        in_frame;
		logic [4:0]  bit_idx;
		logic [5:0]  field;
		logic [30:0] shift;
		logic        ext_pending;
		logic        audio_off;
		logic        id_frame;
		logic        id_valid;
		logic [4:0]  dev_id;
		logic        output_enable_bit;
		logic [7:0]  reply;
		logic [14:0] cmd_log;
		logic        cmd_new;
		logic        rd_active;
		logic [7:0]  rd_data;
		logic        out_en;
		logic        out_bit;
		logic        chain_out;
		logic [23:0] audio_l;
		logic [23:0] audio_r;
		logic        sample_pulse;
		logic        apb_ph;
		logic        err;
		logic [31:0] rdata;
	} port_state_t;

endpackage

/* tb/tb_top.sv */
// Self-checking bench for the multiplexed command/audio port
`timescale 1ns/100ps
module tb_top;
	logic        clock;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        frame_strobe_pin;
	logic        bit_clock_pin;
	logic        serial_in_pin;
	logic        chain_in_pin;
	logic        chain_out_pin;
	logic        read_out_pin_o;
	logic        read_out_pin_oe;
	logic [23:0] audio_left;
	logic [23:0] audio_right;
	logic        sample_valid;
	wire         read_line;
	int          num_errors = 0;
	int          comparisons = 0;
	int          valid_count = 0;
	int          v0;
	logic [31:0] rd;
	logic        err;
	logic [31:0] wcmd [4];
	logic        wope [4];
	logic [31:0] rcmd [3];
	logic [7:0]  rbyte [3];

	assign read_line = read_out_pin_oe ? read_out_pin_o : 1'bz;

	tdm_command_audio_port u_dut (.clock(clock), .rst(rst), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .frame_strobe_pin(frame_strobe_pin),
		.bit_clock_pin(bit_clock_pin), .serial_in_pin(serial_in_pin),
		.chain_in_pin(chain_in_pin), .chain_out_pin(chain_out_pin),
		.read_out_pin_o(read_out_pin_o), .read_out_pin_oe(read_out_pin_oe),
		.audio_left(audio_left), .audio_right(audio_right), .sample_valid(sample_valid));

	tdm_host_model u_host (.clock(clock), .read_line(read_line),
		.read_out_pin_oe(read_out_pin_oe), .chain_out_pin(chain_out_pin),
		.frame_strobe_pin(frame_strobe_pin), .bit_clock_pin(bit_clock_pin),
		.serial_in_pin(serial_in_pin), .chain_in_pin(chain_in_pin));

	always #10 clock = ~clock;

	always @(posedge clock) begin
		if (sample_valid === 1'b1) begin
			valid_count <= valid_count + 1;
		end
	end

	function automatic logic [31:0] cmd(input logic ext, input logic cs, input logic [4:0] id,
			input logic rw, input logic [6:0] r, input logic [7:0] d);
		return {1'b0, ext, cs, id, rw, r, d, 8'h00};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int   n;
		logic ready;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		// Sampled mid-cycle, so the answer judged is the one the next edge takes
		do begin
			@(negedge clock);
			ready = pready;
			rd = prdata;
			err = pslverr;
			@(posedge clock);
			n++;
		end while (ready !== 1'b1 && n < 50);
		if (ready !== 1'b1) begin
			num_errors++;
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd & mask, exp);
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge clock);
		num_errors++;
		wrap_up();
	end

	initial begin
		clock = 1'b0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		wcmd = '{cmd(0, 1, tdm_pkg::ID_TOP, 0, tdm_pkg::OEB_REG_ID, 8'h10),
			cmd(0, 0, tdm_pkg::ID_NONE, 0, tdm_pkg::OEB_REG_ID, 8'h10),
			cmd(0, 0, tdm_pkg::ID_TOP, 0, tdm_pkg::OEB_REG_ID, 8'h10),
			cmd(0, 0, tdm_pkg::ID_BROADCAST, 0, tdm_pkg::OEB_REG_ID, 8'h00)};
		wope = '{1'b0, 1'b0, 1'b1, 1'b0};
		rcmd = '{cmd(0, 0, tdm_pkg::ID_TOP, 1, tdm_pkg::DEVID_REG_ID, 8'h00),
			cmd(0, 0, tdm_pkg::ID_TOP, 1, 7'h05, 8'h00),
			cmd(0, 0, 5'h02, 1, tdm_pkg::DEVID_REG_ID, 8'h00)};
		rbyte = '{8'h01, 8'ha5, 8'h00};
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		apb(1'b0, 8'h40, 32'h0);
		chk(32'(err), 32'h1);
		// Wrong strobe widths, then one qualifying frame: still not in mode
		u_host.frame(wcmd[3] | 32'h10_00, 32'h0, 32'h0, 2, 3, 0);
		u_host.frame(wcmd[3] | 32'h10_00, 32'h0, 32'h0, 2, 3, 0);
		u_host.frame(32'h0, 32'h0, 32'h0, 2, 2, 0);
		rd_chk(tdm_pkg::STATUS_OFF, 32'h1, 32'h0);
		// Broadcast channel-skip write in the entry frame must not act
		u_host.frame(wcmd[3] | 32'h10_00, 32'h0, 32'h0, 2, 2, 0);
		rd_chk(tdm_pkg::STATUS_OFF, 32'h1, 32'h1);
		rd_chk(tdm_pkg::CTRL_OFF, 32'h1, 32'h0);
		u_host.frame(32'h8000_0000 | wcmd[3] | 32'h10_00, 32'h0, 32'h0, 2, 2, 34);
		rd_chk(tdm_pkg::STATUS_OFF, 32'h1f03, 32'h0303);
		rd_chk(tdm_pkg::CTRL_OFF, 32'h1, 32'h0);
		u_host.frame(32'h8000_0000, 32'h0, 32'h0, 2, 2, 0);
		rd_chk(tdm_pkg::STATUS_OFF, 32'h1f03, 32'h0103);
		for (int i = 0; i < 4; i++) begin
			u_host.frame(wcmd[i], 32'h0, 32'h0, 2, 2, 0);
			rd_chk(tdm_pkg::CTRL_OFF, 32'h1, 32'(wope[i]));
		end
		// Last addressed write was the broadcast one, logged with the new flag
		rd_chk(tdm_pkg::CMD_OFF, 32'h0001_7fff, 32'h0001_1300);
		apb(1'b1, tdm_pkg::CMD_OFF, 32'h0001_0000);
		rd_chk(tdm_pkg::CMD_OFF, 32'h0001_7fff, 32'h0000_1300);
		apb(1'b1, tdm_pkg::REPLY_OFF, 32'h0000_00a5);
		for (int i = 0; i < 3; i++) begin
			u_host.frame(rcmd[i], 32'h0, 32'h0, 2, 2, 0);
			for (int k = 0; k < 32; k++) begin
				chk(32'(u_host.oe_seen[k]), 32'h0);
				chk(32'(u_host.oe_seen[32 + k]), 32'(i < 2 && k >= 8 && k <= 16));
				if (i < 2 && k >= 9 && k <= 16) begin
					chk(32'(u_host.rd_seen[32 + k]), 32'(rbyte[i][16 - k]));
				end
			end
		end
		v0 = valid_count;
		u_host.frame(32'h0, 32'h1234_56ab, 32'h89ab_cd5e, 3, 2, 0);
		chk(32'(valid_count - v0), 32'h1);
		chk({audio_left, audio_right[23:16]}, 32'h1234_5689);
		chk({8'h00, audio_right}, 32'h0089_abcd);
		chk({u_host.co_seen[40], u_host.co_seen[70]}, 32'h1);
		v0 = valid_count;
		u_host.frame(cmd(1, 0, 5'h00, 0, 7'h00, 8'h00), wcmd[2], 32'h5555_5500, 3, 2, 0);
		rd_chk(tdm_pkg::CTRL_OFF, 32'h1, 32'h1);
		chk(32'(valid_count - v0), 32'h0);
		u_host.frame(32'h0, 32'h7777_7700, 32'h6666_6600, 3, 2, 0);
		chk(32'(valid_count - v0), 32'h0);
		chk({8'h00, audio_left}, 32'h0012_3456);
		wrap_up();
	end
endmodule

/* tb/tdm_host_model.sv */
// Host controller model driving the multiplexed command/audio link
`timescale 1ns/100ps
module tdm_host_model (
	input  wire logic clock,
	input  wire logic read_line,
	input  wire logic read_out_pin_oe,
	input  wire logic chain_out_pin,
	output logic      frame_strobe_pin,
	output logic      bit_clock_pin,
	output logic      serial_in_pin,
	output logic      chain_in_pin
);
	logic [0:95] oe_seen;
	logic [0:95] rd_seen;
	logic [0:95] co_seen;

	initial begin
		frame_strobe_pin = 1'b0;
		bit_clock_pin = 1'b0;
		serial_in_pin = 1'b0;
		chain_in_pin = 1'b0;
	end

	// One frame of nf fields, strobe high for hi rises, chain input high from bit chain_at
	task automatic frame(input logic [31:0] f0, input logic [31:0] f1, input logic [31:0] f2,
			input int nf, input int hi, input int chain_at);
		logic [95:0] bits;
		bits = {f0, f1, f2};
		for (int k = 0; k < nf * 32; k++) begin
			serial_in_pin <= bits[95 - k];
			// one shared strobe, width picked per frame
			frame_strobe_pin <= (k < hi);
			chain_in_pin <= (k >= chain_at);
			repeat (4) @(posedge clock);
			bit_clock_pin <= 1'b1;
			repeat (4) @(posedge clock);
			// Late in the high phase the value from the last fall still stands
			oe_seen[k] = read_out_pin_oe;
			rd_seen[k] = read_line;
			co_seen[k] = chain_out_pin;
			bit_clock_pin <= 1'b0;
		end
		// Released line shows the inverse, never a held last bit
		serial_in_pin <= ~bits[96 - nf * 32];
		frame_strobe_pin <= 1'b0;
		repeat (64) @(posedge clock);
	endtask
endmodule
